// ### common/vic_pkg.sv
// ==========================================================================
// Register map, field layout and mode codes of the interrupt command block.
// ==========================================================================
package vic_pkg;

  // ========================================================================
  // Register byte addresses on the APB.
  // ========================================================================
  localparam logic [31:0] VIC_ADDR_MASK_READ = 32'hfff82114;
  localparam logic [31:0] VIC_ADDR_MASK_SET = 32'hfff82120;
  localparam logic [31:0] VIC_ADDR_MASK_DISABLE = 32'hfff82124;
  localparam logic [31:0] VIC_ADDR_SOURCE_SET = 32'hfff82128;
  localparam logic [31:0] VIC_ADDR_SOURCE_CLEAR = 32'hfff8212c;
  localparam logic [31:0] VIC_ADDR_END_OF_SERVICE = 32'hfff82130;
  localparam logic [31:0] VIC_ADDR_PENDING = 32'hfff82140;
  localparam logic [31:0] VIC_ADDR_ACTIVE = 32'hfff82144;
  localparam logic [31:0] VIC_ADDR_EXT_STATUS = 32'hfff82148;
  localparam logic [31:0] VIC_ADDR_EXT_CFG = 32'hfff8214c;
  localparam logic [31:0] VIC_ADDR_EVT_STATUS = 32'hfff82150;
  localparam logic [31:0] VIC_ADDR_EVT_MASK = 32'hfff82154;
  localparam logic [31:0] VIC_ADDR_DEBUG_HOLD = 32'hfff82200;

  // ========================================================================
  // Field positions and widths.
  // ========================================================================
  localparam int VIC_CH_LO = 1;
  localparam int VIC_CH_HI = 31;
  localparam int VIC_CH_EXT = 31;
  localparam int VIC_NUM_W = 5;
  localparam int VIC_DEBUG_BIT = 0;
  localparam int VIC_PEND_VALID_BIT = 31;
  localparam int VIC_EXT_N = 2;
  localparam int VIC_MODE_W = 2;
  localparam int VIC_EVT_N = 3;
  localparam int VIC_EVT_EXT_A = 0;
  localparam int VIC_EVT_EXT_B = 1;
  localparam int VIC_EVT_SERVICE = 2;

  // ========================================================================
  // Trigger mode codes of each external input.
  // ========================================================================
  localparam logic [1:0] VIC_MODE_LOW = 2'h0;
  localparam logic [1:0] VIC_MODE_HIGH = 2'h1;
  localparam logic [1:0] VIC_MODE_RISE = 2'h2;
  localparam logic [1:0] VIC_MODE_FALL = 2'h3;

  // ========================================================================
  // Reset values.
  // ========================================================================
  localparam logic [31:1] VIC_RST_CHANNELS = 31'h0;
  localparam logic [3:0] VIC_RST_EXT_CFG = 4'h0;
  localparam logic [31:0] VIC_RST_WORD = 32'h0;

endpackage : vic_pkg

// ### hdl/vic_ext_detect.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Synchroniser and trigger detector for the two external interrupt pins.
// ==========================================================================
module vic_ext_detect
  import vic_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Raw pins from outside the clock domain.
  input wire logic ext_irq_a,
  input wire logic ext_irq_b,
  // Trigger modes, two bits per input, input a in the low pair.
  input wire logic [3:0] ext_cfg,
  // One bit per input, high while its trigger condition holds.
  output logic [1:0] ext_trig
);

  // All flip-flops of the detector.
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] prev;
  } vic_det_s;

  vic_det_s st;
  vic_det_s next_st;

  // ========================================================================
  // Next state: two-stage synchroniser, then a history stage.
  // ========================================================================
  always_comb begin
    next_st = st;
    next_st.meta = {ext_irq_b, ext_irq_a};
    // The first stage feeds only the second, so metastability stays contained.
    next_st.sync = st.meta;
    next_st.prev = st.sync;
  end

  // State register. The stages reset to the high idle level of the active-low pins,
  // so low mode does not fire and edge modes see no false edge after reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '1;
    end else begin
      st <= next_st;
    end
  end

  // ========================================================================
  // Per-input trigger decode.
  // ========================================================================
  for (genvar g = 0; g < VIC_EXT_N; g++) begin : g_det
    logic [1:0] mode;
    assign mode = ext_cfg[g*VIC_MODE_W +: VIC_MODE_W];
    assign ext_trig[g] = (mode == VIC_MODE_LOW) ? !st.sync[g] :
                         (mode == VIC_MODE_HIGH) ? st.sync[g] :
                         (mode == VIC_MODE_RISE) ? (st.sync[g] && !st.prev[g]) :
                         (!st.sync[g] && st.prev[g]);
  end

  // ========================================================================
  // Checks.
  // ========================================================================
  // A rising edge in rising mode triggers on the cycle the edge is seen.
  property p_rise_trig;
    @(posedge pclk) disable iff (!presetn)
      (ext_cfg[1:0] == VIC_MODE_RISE) && $rose(st.sync[0]) |-> ext_trig[0];
  endproperty
  a_rise_trig: assert property (p_rise_trig) else $error("rising edge missed");

  // A falling input in rising mode never triggers.
  property p_fall_quiet;
    @(posedge pclk) disable iff (!presetn)
      (ext_cfg[3:2] == VIC_MODE_RISE) && $fell(st.sync[1]) |-> !ext_trig[1];
  endproperty
  a_fall_quiet: assert property (p_fall_quiet) else $error("wrong edge triggered");

endmodule : vic_ext_detect
`default_nettype wire

// ### hdl/vic_command_regs.sv
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Command registers of the vectored interrupt controller.
// ==========================================================================
module vic_command_regs
  import vic_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral interrupt sources, same clock, level high.
  input wire logic [30:1] src_in,
  // External interrupt pins.
  input wire logic ext_irq_a,
  input wire logic ext_irq_b,
  // Toward the processor core.
  output logic irq_to_core,
  // Block event interrupt.
  output logic irq_out
);

  // ========================================================================
  // State.
  // ========================================================================
  // Every flip-flop of the block except src_q and the detector stages in u_ext lives in this one struct.
  typedef struct packed {
    logic [31:1] enable;       // Channel enable bits.
    logic [31:1] active;       // Channel activity, tracked regardless of enable.
    logic dbg_hold;            // Debug hold mode.
    logic [4:0] pend_num;      // Captured pending channel number.
    logic pend_valid;          // Pending vector holds a channel.
    logic in_service;          // A channel has been stacked into service.
    logic [4:0] svc_num;       // Number of the channel under service.
    logic [1:0] ext_status;    // Which external input fired.
    logic [3:0] ext_cfg;       // Trigger modes of the external inputs.
    logic [2:0] evt_status;    // Sticky block events.
    logic [2:0] evt_mask;      // Event interrupt enables.
    logic [31:0] rdata;        // Read data held for the access phase.
  } vic_state_s;

  vic_state_s st;
  vic_state_s next_st;

  logic [1:0] ext_trig;       // Trigger conditions of the external inputs.
  logic [31:1] src_all;       // All hardware sources by channel.
  logic [31:1] fire;          // Active and enabled channels.
  logic wr_acc;               // Write access phase.
  logic rd_acc;               // Read access phase.
  logic rd_setup;             // Read setup phase.
  logic mapped;               // Address hits a register.
  logic [4:0] top_num;        // Highest firing channel.

  // ========================================================================
  // External input detector.
  // ========================================================================
  vic_ext_detect u_ext (
    .pclk(pclk),
    .presetn(presetn),
    .ext_irq_a(ext_irq_a),
    .ext_irq_b(ext_irq_b),
    .ext_cfg(st.ext_cfg),
    .ext_trig(ext_trig)
  );

  assign src_all = {|ext_trig, src_in};

  assign fire = st.active & st.enable;
  assign irq_to_core = |fire;
  assign irq_out = |(st.evt_status & st.evt_mask);

  // ========================================================================
  // APB decode. The slave never waits, so every access is two cycles.
  // ========================================================================
  assign pready = 1'b1;
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign prdata = st.rdata;

  // Address decode, shared by the error answer.
  always_comb begin
    case (paddr)
      VIC_ADDR_MASK_READ, VIC_ADDR_MASK_SET, VIC_ADDR_MASK_DISABLE,
      VIC_ADDR_SOURCE_SET, VIC_ADDR_SOURCE_CLEAR, VIC_ADDR_END_OF_SERVICE,
      VIC_ADDR_PENDING, VIC_ADDR_ACTIVE, VIC_ADDR_EXT_STATUS, VIC_ADDR_EXT_CFG,
      VIC_ADDR_EVT_STATUS, VIC_ADDR_EVT_MASK, VIC_ADDR_DEBUG_HOLD: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // An unmapped address is refused in its access phase.
  assign pslverr = psel && penable && !mapped;

  // ========================================================================
  // Highest-numbered firing channel. Priority logic proper sits elsewhere.
  // ========================================================================
  always_comb begin
    top_num = '0;
    for (int i = VIC_CH_LO; i <= VIC_CH_HI; i++) begin
      if (fire[i]) begin
        top_num = 5'(i);
      end
    end
  end

  // ========================================================================
  // Next state.
  // ========================================================================
  always_comb begin
    next_st = st;

    // Read data is fetched in the setup phase so it is ready from a flop.
    if (rd_setup) begin
      case (paddr)
        VIC_ADDR_MASK_READ: begin
          next_st.rdata = {st.enable, 1'b0};
        end
        VIC_ADDR_PENDING: begin
          next_st.rdata = VIC_RST_WORD;
          next_st.rdata[VIC_PEND_VALID_BIT] = st.pend_valid;
          next_st.rdata[VIC_NUM_W-1:0] = st.pend_num;
        end
        VIC_ADDR_ACTIVE: begin
          next_st.rdata = {st.active, 1'b0};
        end
        VIC_ADDR_EXT_STATUS: begin
          next_st.rdata = {30'h0, st.ext_status};
        end
        VIC_ADDR_EXT_CFG: begin
          next_st.rdata = {28'h0, st.ext_cfg};
        end
        VIC_ADDR_EVT_STATUS: begin
          next_st.rdata = {29'h0, st.evt_status};
        end
        VIC_ADDR_EVT_MASK: begin
          next_st.rdata = {29'h0, st.evt_mask};
        end
        default: begin
          next_st.rdata = VIC_RST_WORD;
        end
      endcase
    end

    // Plain register writes.
    if (wr_acc) begin
      case (paddr)
        VIC_ADDR_MASK_SET: begin
          next_st.enable = st.enable | pwdata[31:1];
        end
        VIC_ADDR_MASK_DISABLE: begin
          next_st.enable = st.enable & ~pwdata[31:1];
        end
        VIC_ADDR_EXT_CFG: begin
          next_st.ext_cfg = pwdata[3:0];
        end
        VIC_ADDR_EVT_MASK: begin
          next_st.evt_mask = pwdata[2:0];
        end
        VIC_ADDR_DEBUG_HOLD: begin
          next_st.dbg_hold = pwdata[VIC_DEBUG_BIT];
        end
        default: begin
          next_st.enable = st.enable;
        end
      endcase
    end

    if (wr_acc && paddr == VIC_ADDR_SOURCE_CLEAR) begin
      next_st.active = st.active & ~pwdata[31:1];
    end
    next_st.active = next_st.active | src_all;
    if (wr_acc && paddr == VIC_ADDR_SOURCE_SET) begin
      next_st.active = next_st.active | pwdata[31:1];
    end

    // external status, write one clears, new trigger wins.
    if (wr_acc && paddr == VIC_ADDR_EXT_STATUS) begin
      next_st.ext_status = st.ext_status & ~pwdata[1:0];
    end
    next_st.ext_status = next_st.ext_status | ext_trig;

    // Block events: external triggers and end of service.
    if (wr_acc && paddr == VIC_ADDR_EVT_STATUS) begin
      next_st.evt_status = st.evt_status & ~pwdata[2:0];
    end
    next_st.evt_status[VIC_EVT_EXT_A] = next_st.evt_status[VIC_EVT_EXT_A] | ext_trig[0];
    next_st.evt_status[VIC_EVT_EXT_B] = next_st.evt_status[VIC_EVT_EXT_B] | ext_trig[1];

    if (wr_acc && paddr == VIC_ADDR_END_OF_SERVICE) begin
      next_st.in_service = 1'b0;
      next_st.evt_status[VIC_EVT_SERVICE] = 1'b1;
    end

    if (rd_acc && paddr == VIC_ADDR_PENDING && !st.dbg_hold && st.pend_valid) begin
      next_st.pend_valid = 1'b0;
      next_st.in_service = 1'b1;
      next_st.svc_num = st.pend_num;
    end
    // debug hold stacks on write only.
    if (wr_acc && paddr == VIC_ADDR_PENDING && st.dbg_hold && st.pend_valid) begin
      next_st.pend_valid = 1'b0;
      next_st.in_service = 1'b1;
      next_st.svc_num = st.pend_num;
    end

    // Capture a new vector only while nothing is pending or in service.
    if (!st.pend_valid && !st.in_service && (|fire)) begin
      next_st.pend_valid = 1'b1;
      next_st.pend_num = top_num;
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ========================================================================
  // Checks.
  // ========================================================================
  logic [31:1] src_q;  // Sources one cycle back, for the unforce check.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= VIC_RST_CHANNELS;
    end else begin
      src_q <= src_all;
    end
  end

  property p_mask_clear;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == VIC_ADDR_MASK_DISABLE |=> (st.enable & $past(pwdata[31:1])) == '0;
  endproperty
  a_mask_clear: assert property (p_mask_clear) else $error("mask clear failed");

  property p_mask_set;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == VIC_ADDR_MASK_SET |=>
        (st.enable & $past(pwdata[31:1])) == $past(pwdata[31:1]);
  endproperty
  a_mask_set: assert property (p_mask_set) else $error("mask set failed");

  property p_force;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == VIC_ADDR_SOURCE_SET |=>
        (st.active & $past(pwdata[31:1])) == $past(pwdata[31:1]);
  endproperty
  a_force: assert property (p_force) else $error("force failed");

  property p_unforce;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == VIC_ADDR_SOURCE_CLEAR |=>
        (st.active & $past(pwdata[31:1]) & ~src_q) == '0;
  endproperty
  a_unforce: assert property (p_unforce) else $error("unforce failed");

  property p_eos;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == VIC_ADDR_END_OF_SERVICE |=> !st.in_service ##1 1'b1;
  endproperty
  a_eos: assert property (p_eos) else $error("service not ended");

  property p_dbg_read_keeps;
    @(posedge pclk) disable iff (!presetn)
      rd_acc && paddr == VIC_ADDR_PENDING && st.dbg_hold && st.pend_valid |=>
        st.pend_valid && st.pend_num == $past(st.pend_num);
  endproperty
  a_dbg_read_keeps: assert property (p_dbg_read_keeps) else $error("debug read cleared");

  property p_dbg_write_stacks;
    @(posedge pclk) disable iff (!presetn)
      wr_acc && paddr == VIC_ADDR_PENDING && st.dbg_hold && st.pend_valid |=>
        st.in_service && !st.pend_valid && st.svc_num == $past(st.pend_num);
  endproperty
  a_dbg_write_stacks: assert property (p_dbg_write_stacks) else $error("debug stack failed");

  property p_normal_read_clears;
    @(posedge pclk) disable iff (!presetn)
      rd_acc && paddr == VIC_ADDR_PENDING && !st.dbg_hold && st.pend_valid |=>
        !st.pend_valid && st.in_service;
  endproperty
  a_normal_read_clears: assert property (p_normal_read_clears) else $error("read did not clear");

  property p_ext_channel;
    @(posedge pclk) disable iff (!presetn)
      ext_trig != 2'h0 |=> st.active[VIC_CH_EXT] && st.ext_status != 2'h0;
  endproperty
  a_ext_channel: assert property (p_ext_channel) else $error("external not on 31");

  property p_ext_status;
    @(posedge pclk) disable iff (!presetn)
      ext_trig[1] |=> st.ext_status[1] ##1 st.ext_status[1] || $past(wr_acc);
  endproperty
  a_ext_status: assert property (p_ext_status) else $error("status lost");

  property p_gate;
    @(posedge pclk) disable iff (!presetn)
      (st.active & st.enable) == '0 |-> !irq_to_core;
  endproperty
  a_gate: assert property (p_gate) else $error("disabled channel forwarded");

  property p_cmd_reads_zero;
    @(posedge pclk) disable iff (!presetn)
      rd_setup && paddr == VIC_ADDR_SOURCE_SET |=> prdata == VIC_RST_WORD;
  endproperty
  a_cmd_reads_zero: assert property (p_cmd_reads_zero) else $error("command read nonzero");

  c_normal_read: cover property (@(posedge pclk) rd_acc && paddr == VIC_ADDR_PENDING && st.pend_valid);
  c_debug_stack: cover property (@(posedge pclk) wr_acc && paddr == VIC_ADDR_PENDING && st.dbg_hold);
  c_ext_both: cover property (@(posedge pclk) ext_trig == 2'h3);
  c_irq_out: cover property (@(posedge pclk) irq_out && irq_to_core);

endmodule : vic_command_regs
`default_nettype wire

// ### testbench/vic_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Processor core request input, seen from the controller side.
// ==========================================================================
module vic_core_model
  import vic_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Request level from the controller.
  input wire logic irq_to_core,
  // Number of request rises taken by the core.
  output logic [7:0] req_count
);
  // Request level at the previous edge.
  logic last_req;

  // counts forwarded requests.
  // The core only reacts to a new request, so a held level counts once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_req <= 1'b0;
      req_count <= 8'h0;
    end else begin
      last_req <= irq_to_core;
      if (irq_to_core && !last_req) begin
        req_count <= req_count + 8'h1;
      end
    end
  end
endmodule : vic_core_model
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Self-checking bench for the command registers.
// ==========================================================================
module testbench
  import vic_pkg::*;
;
  // Bus, source and pin drives, all idle at time zero.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic [30:1] src_in = 30'h0;
  logic ext_irq_a = 1'b1;
  logic ext_irq_b = 1'b1;
  // Design and model outputs.
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic irq_to_core;
  wire logic irq_out;
  wire logic [7:0] req_count;
  // Counters, last bus answer and scratch values.
  int fails = 0;
  int check_count = 0;
  logic [31:0] rdat;
  logic rerr;
  logic [7:0] base;
  logic [1:0] idle;
  localparam logic [31:0] ones = 32'hffffffff;

  // Clock at 40 MHz.
  always #12.5 pclk = ~pclk;

  vic_command_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_in(src_in),
    .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b), .irq_to_core(irq_to_core), .irq_out(irq_out));
  vic_core_model core (.pclk(pclk), .presetn(presetn), .irq_to_core(irq_to_core), .req_count(req_count));

  // ========================================================================
  // Shared tasks.
  // ========================================================================
  // Compares with case equality so an unknown never matches.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic is_wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= is_wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // The write lands at the answer edge; one more edge lets its effect show on the outputs.
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    @(posedge pclk);
  endtask : wr
  // Reads and compares the bits selected by the mask.
  task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rdat & m);
  endtask : rd
  task automatic done_test(input string name);
    $display("Test %s done", name);
  endtask : done_test
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // ========================================================================
  // Watchdog, far beyond the few hundred cycles the tests need.
  // ========================================================================
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    print_verdict();
  end

  // ========================================================================
  // Test sequence.
  // ========================================================================
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(VIC_ADDR_MASK_READ, ones, 32'h0, "mask rst");
    rd(VIC_ADDR_SOURCE_SET, ones, 32'h0, "cmd read"); // reads.
    rd(VIC_ADDR_DEBUG_HOLD, ones, 32'h0, "dbg read"); // reads.
    rd(32'hfff82300, ones, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, rerr});
    done_test("reset");
    wr(VIC_ADDR_MASK_SET, ones); // set.
    rd(VIC_ADDR_MASK_READ, ones, 32'hfffffffe, "mask set"); // set.
    wr(VIC_ADDR_MASK_DISABLE, 32'h0000000f); // clear.
    rd(VIC_ADDR_MASK_READ, ones, 32'hfffffff0, "mask clr"); // clear.
    wr(VIC_ADDR_MASK_SET, 32'h0); // zeros.
    wr(VIC_ADDR_MASK_DISABLE, 32'h0); // zeros.
    rd(VIC_ADDR_MASK_READ, ones, 32'hfffffff0, "mask keep"); // zeros.
    wr(VIC_ADDR_MASK_DISABLE, ones); // clear.
    wr(VIC_ADDR_MASK_SET, 32'h00000100); // set.
    done_test("mask");
    base = req_count;
    wr(VIC_ADDR_SOURCE_SET, 32'h00000207); // force.
    rd(VIC_ADDR_ACTIVE, ones, 32'h00000206, "force"); // force.
    chk("core off", 32'h0, {31'h0, irq_to_core}); // gated.
    wr(VIC_ADDR_SOURCE_CLEAR, 32'h00000005); // unforce.
    rd(VIC_ADDR_ACTIVE, ones, 32'h00000202, "unforce"); // unforce.
    wr(VIC_ADDR_SOURCE_SET, 32'h00000100); // force.
    chk("core on", 32'h1, {31'h0, irq_to_core}); // forwarded.
    // The core model counts the rise at the edge after the level appears.
    @(posedge pclk);
    chk("core req", {24'h0, base + 8'h1}, {24'h0, req_count}); // forwarded.
    done_test("source");
    rd(VIC_ADDR_PENDING, ones, 32'h80000008, "pend"); // normal.
    rd(VIC_ADDR_PENDING, 32'h80000000, 32'h0, "pend clr"); // normal.
    wr(VIC_ADDR_END_OF_SERVICE, 32'h5a5a5a5a); // done.
    rd(VIC_ADDR_EVT_STATUS, 32'h4, 32'h4, "eos evt"); // done.
    rd(VIC_ADDR_PENDING, ones, 32'h80000008, "recapture"); // done.
    wr(VIC_ADDR_END_OF_SERVICE, 32'h0); // done.
    wr(VIC_ADDR_DEBUG_HOLD, 32'h1); // hold.
    rd(VIC_ADDR_PENDING, ones, 32'h80000008, "hold 1"); // hold.
    rd(VIC_ADDR_PENDING, ones, 32'h80000008, "hold 2"); // hold.
    wr(VIC_ADDR_PENDING, 32'h0); // stacking.
    rd(VIC_ADDR_PENDING, 32'h80000000, 32'h0, "stacked"); // stacking.
    wr(VIC_ADDR_DEBUG_HOLD, 32'h0); // normal.
    wr(VIC_ADDR_END_OF_SERVICE, 32'h0); // done.
    done_test("service");
    // The service event is masked, then unmasked, then cleared.
    chk("irq mask", 32'h0, {31'h0, irq_out});
    wr(VIC_ADDR_EVT_MASK, 32'h4);
    chk("irq on", 32'h1, {31'h0, irq_out});
    wr(VIC_ADDR_EVT_STATUS, 32'h4);
    chk("irq clr", 32'h0, {31'h0, irq_out});
    done_test("event");
    wr(VIC_ADDR_MASK_DISABLE, 32'h00000100); // clear.
    chk("core gate", 32'h0, {31'h0, irq_to_core}); // gated.
    rd(VIC_ADDR_ACTIVE, ones, 32'h00000302, "kept"); // tracked.
    wr(VIC_ADDR_SOURCE_CLEAR, ones); // unforce.
    src_in[5] <= 1'b1;
    wr(VIC_ADDR_SOURCE_CLEAR, 32'h00000020); // unforce.
    rd(VIC_ADDR_ACTIVE, ones, 32'h00000020, "src held");
    src_in[5] <= 1'b0;
    wr(VIC_ADDR_SOURCE_CLEAR, 32'h00000020); // unforce.
    rd(VIC_ADDR_ACTIVE, ones, 32'h0, "src gone"); // unforce.
    done_test("activity");
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        idle = 2'b11;
        idle[p] = (m == 0 || m == 3);
        ext_irq_a <= idle[0];
        ext_irq_b <= idle[1];
        wr(VIC_ADDR_EXT_CFG, 32'(m << (2 * p))); // mode.
        repeat (6) @(posedge pclk);
        wr(VIC_ADDR_SOURCE_CLEAR, 32'h80000000); // unforce.
        wr(VIC_ADDR_EXT_STATUS, 32'h3);
        rd(VIC_ADDR_EXT_STATUS, 32'h3, 32'h0, "ext idle"); // quiet.
        if (p == 0) ext_irq_a <= ~idle[0];
        else ext_irq_b <= ~idle[1];
        repeat (6) @(posedge pclk);
        rd(VIC_ADDR_EXT_STATUS, 32'h3, 32'(1 << p), "ext which"); // source.
        rd(VIC_ADDR_ACTIVE, 32'h80000000, 32'h80000000, "ch31"); // shared.
      end
    end
    done_test("external");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
